/* core/prn_ctrl.sv */
// Dot-matrix printer controller: APB host port, command decoder, print engine
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/100ps
module prn_ctrl #(
	parameter int CLK_HZ = 20_000_000
) (
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Host-side shared pins
	input  wire logic        ack_or_serial_in_i,
	output logic             request_or_send_ok_o,
	input  wire logic        irq_or_serial_strap_i,
	output logic             irq_or_serial_strap_o,
	output logic             irq_or_serial_strap_oe_o,
	input  wire logic [2:0]  baud_strap_i,
	// Printer sense inputs
	input  wire logic        paper_advance_switch_i,
	input  wire logic        form_top_sense_i,
	input  wire logic        head_park_i,
	// Printer drive outputs
	output logic             main_drive_out_n_o,
	output logic             feed_drive_out_n_o,
	output logic             solenoid_pulse_out_o,
	output logic      [6:0]  needle_drive_outs_n_o,
	output logic             aux_out_one_o,
	output logic             aux_out_two_o,
	output logic             cycle_strobe_o
);
	// ********************************
	// Derived cycle counts
	// ********************************
	localparam int MHZ       = CLK_HZ / 1_000_000;
	localparam int SYNC_HALF = (MHZ * prn_pkg::SYNC_NS / 2000 < 1) ? 1 :
		MHZ * prn_pkg::SYNC_NS / 2000;
	localparam int CW        = prn_pkg::CNT_W;
	localparam logic [CW-1:0] COL12_CYC = CW'(MHZ * prn_pkg::COL12_US);
	localparam logic [CW-1:0] COL10_CYC = CW'(MHZ * prn_pkg::COL10_US);
	localparam logic [CW-1:0] LF_CYC    = CW'(MHZ * prn_pkg::LF_US);

	// Pseudo glyph: rotated code bits per column, space is blank
	function automatic logic [6:0] glyph(input logic [5:0] k, input logic [2:0] c);
		logic [13:0] g;
		g = {2{^k, k}} >> c;
		return (k == 6'h00) ? 7'h00 : g[6:0];
	endfunction : glyph

	function automatic logic [CW-1:0] baud_div(input logic [2:0] c);
		return CW'(CLK_HZ / prn_pkg::baud_rate(c));
	endfunction : baud_div

	logic                rst_q1_r, rst_r, strap_done_r, serial_r;
	logic [1:0]          settle_r;
	logic [7:0]          s1_r, s2_r, s3_r;
	prn_pkg::pins_t      pin_r;
	logic                pready_r, pslverr_r, ibf_r, take, wr_ok;
	logic [31:0]         prdata_r, status;
	logic [7:0]          in_byte_r, tab_r [3];
	logic                aux1_r, aux2_r, cpi10_r, dbl_r, right_r, dma_r;
	logic [2:0]          stb_code_r;
	logic [15:0]         dma_cnt_r;
	logic [5:0]          len_r, line_max, prn_len_nxt, pr_len_r, idx_r, chr_idx;
	logic [5:0]          buf_r [prn_pkg::LINE_MAX];
	prn_pkg::param_t     param_r;
	prn_pkg::eng_t       eng_r;
	logic                is_cmd, is_chr, full_now, start_print, feed_cmd, form_cmd;
	logic [7:0]          feed_n, lf_left_r;
	logic [3:0]          col_r, col_last;
	logic [2:0]          gcol;
	logic [CW-1:0]       cnt_r, col_cyc, stb_cyc, rx_cnt_r, sync_cnt_r, stb_len_r;
	logic                fire, rx_busy_r, rx_done_r;
	logic [3:0]          rx_bit_r;
	logic [7:0]          rx_sh_r;
	logic                req_r, irq_r, oe_r, cyc_r, stb_out_r, main_n_r, feed_n_r;
	logic [6:0]          needle_n_r;

	// ********************************
	// Reset and pin synchronisers
	// ********************************
	// Reset is retimed before use so release is clean everywhere
	always_ff @(posedge mclk_i) begin
		rst_q1_r <= reset_i;
		rst_r    <= rst_q1_r;
	end

	// Three stages; a level counts once stages two and three agree
	always_ff @(posedge mclk_i) begin
		s1_r <= {baud_strap_i, irq_or_serial_strap_i, ack_or_serial_in_i,
			head_park_i, form_top_sense_i, paper_advance_switch_i};
		s2_r <= s1_r;
		s3_r <= s2_r;
	end

	always_ff @(posedge mclk_i) begin
		if (rst_r) begin
			pin_r <= '0;
		end else begin
			pin_r <= prn_pkg::pins_t'((s3_r & (s2_r ~^ s3_r)) | (pin_r & (s2_r ^ s3_r)));
		end
	end

	// Strap is caught a few cycles after release, once the filter settled
	always_ff @(posedge mclk_i) begin
		if (rst_r) begin
			settle_r     <= '0;
			strap_done_r <= 1'b0;
			serial_r     <= 1'b0;
		end else if (!strap_done_r) begin
			settle_r <= settle_r + 2'h1;
			if (settle_r == 2'h3) begin
				strap_done_r <= 1'b1;
				serial_r     <= ~pin_r.strap;
			end
		end
	end

	// ********************************
	// APB slave and input byte
	// ********************************
	always_comb begin
		status                    = '0;
		status[prn_pkg::ST_PARAM] = (param_r != prn_pkg::P_NONE);
		status[prn_pkg::ST_DMA]   = dma_r;
		status[prn_pkg::ST_FULL]  = ibf_r;
	end

	// Writes need select; in DMA mode the acknowledge is needed as well
	assign wr_ok = psel_i && penable_i && pready_r && pwrite_i && strap_done_r &&
		!serial_r && (paddr_i == prn_pkg::ADDR_DATA) && !ibf_r &&
		(!dma_r || pin_r.ack);

	// One wait-free access: ready rises in the access phase
	always_ff @(posedge mclk_i) begin
		if (rst_r) begin
			pready_r  <= 1'b0;
			prdata_r  <= '0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= psel_i && !penable_i && !pready_r;
			if (psel_i && !penable_i) begin
				prdata_r  <= (!pwrite_i && paddr_i == prn_pkg::ADDR_STATUS) ? status : '0;
				pslverr_r <= paddr_i != prn_pkg::ADDR_DATA && paddr_i != prn_pkg::ADDR_STATUS;
			end
		end
	end

	// Set wins over consume so no byte is lost
	always_ff @(posedge mclk_i) begin
		if (rst_r) begin
			ibf_r     <= 1'b0;
			in_byte_r <= '0;
		end else if (wr_ok || rx_done_r) begin
			ibf_r     <= 1'b1;
			in_byte_r <= wr_ok ? pwdata_i[7:0] : rx_sh_r;
		end else if (take) begin
			ibf_r <= 1'b0;
		end
	end

	// ********************************
	// Serial receiver, 8N1
	// ********************************
	always_ff @(posedge mclk_i) begin
		if (rst_r) begin
			rx_busy_r <= 1'b0;
			rx_done_r <= 1'b0;
			rx_cnt_r  <= '0;
			rx_bit_r  <= '0;
			rx_sh_r   <= '0;
		end else begin
			rx_done_r <= 1'b0;
			if (!rx_busy_r) begin
				if (serial_r && !pin_r.ack) begin
					rx_busy_r <= 1'b1;
					rx_cnt_r  <= baud_div(pin_r.baud) >> 1;
					rx_bit_r  <= '0;
				end
			end else if (rx_cnt_r != '0) begin
				rx_cnt_r <= rx_cnt_r - 1'b1;
			end else begin
				rx_cnt_r <= baud_div(pin_r.baud) - 1'b1;
				rx_bit_r <= rx_bit_r + 4'h1;
				if (rx_bit_r == 4'h0 && pin_r.ack) begin
					rx_busy_r <= 1'b0;
				end else if (rx_bit_r == 4'h9) begin
					rx_busy_r <= 1'b0;
					rx_done_r <= pin_r.ack && !ibf_r;
				end else if (rx_bit_r != 4'h0) begin
					rx_sh_r <= {pin_r.ack, rx_sh_r[7:1]};
				end
			end
		end
	end

	// ********************************
	// Command decoder
	// ********************************
	always_comb begin
		take        = ibf_r && (eng_r == prn_pkg::ENG_IDLE);
		is_cmd      = (in_byte_r[7:5] == 3'h0);
		is_chr      = (in_byte_r >= prn_pkg::CHR_FIRST) && (in_byte_r <= prn_pkg::CHR_LAST);
		line_max    = cpi10_r ? prn_pkg::LINE_10 : prn_pkg::LINE_12;
		line_max    = dbl_r ? (line_max >> 1) : line_max;
		full_now    = is_chr && (len_r + 6'h01 == line_max);
		start_print = take && (param_r == prn_pkg::P_NONE) &&
			((in_byte_r == prn_pkg::CMD_CR) || full_now);
		prn_len_nxt = full_now ? len_r + 6'h01 : len_r;
		feed_n      = (param_r == prn_pkg::P_LF) ? in_byte_r : 8'h01;
		feed_cmd    = take && (((param_r == prn_pkg::P_NONE) && in_byte_r == prn_pkg::CMD_LF) ||
			((param_r == prn_pkg::P_LF) && in_byte_r != 8'h00));
		form_cmd    = take && (param_r == prn_pkg::P_NONE) && in_byte_r == prn_pkg::CMD_FORM;
	end

	// A pending parameter takes the byte before any decoding
	always_ff @(posedge mclk_i) begin
		if (rst_r) begin
			param_r    <= prn_pkg::P_NONE;
			aux1_r     <= 1'b1;
			aux2_r     <= 1'b0;
			cpi10_r    <= 1'b0;
			dbl_r      <= 1'b0;
			stb_code_r <= prn_pkg::STB_RESET_CODE;
			right_r    <= 1'b0;
			dma_r      <= 1'b0;
			dma_cnt_r  <= '0;
			len_r      <= '0;
			tab_r      <= '{default: '0};
		end else if (wr_ok && dma_r) begin
			dma_cnt_r <= dma_cnt_r - 16'h0001;
			if (dma_cnt_r == 16'h0001) begin
				dma_r <= 1'b0;
			end
		end else if (take && param_r != prn_pkg::P_NONE) begin
			param_r <= prn_pkg::P_NONE;
			case (param_r)
				prn_pkg::P_DMA_LO: begin
					dma_cnt_r[7:0] <= in_byte_r;
					param_r        <= prn_pkg::P_DMA_HI;
				end
				prn_pkg::P_DMA_HI: begin
					dma_cnt_r[15:8] <= in_byte_r;
					dma_r           <= ({in_byte_r, dma_cnt_r[7:0]} != 16'h0000);
				end
				prn_pkg::P_TAB1: tab_r[0] <= in_byte_r;
				prn_pkg::P_TAB2: tab_r[1] <= in_byte_r;
				prn_pkg::P_TAB3: tab_r[2] <= in_byte_r;
				prn_pkg::P_STB:  stb_code_r <= in_byte_r[2:0];
				default: ;
			endcase
		end else if (take && is_cmd) begin
			case (in_byte_r)
				prn_pkg::CMD_AUX1_SET: aux1_r <= 1'b1;
				prn_pkg::CMD_AUX2_SET: aux2_r <= 1'b1;
				prn_pkg::CMD_AUX1_CLR: aux1_r <= 1'b0;
				prn_pkg::CMD_AUX2_CLR: aux2_r <= 1'b0;
				prn_pkg::CMD_RESET: begin
					cpi10_r    <= 1'b0;
					dbl_r      <= 1'b0;
					stb_code_r <= prn_pkg::STB_RESET_CODE;
					right_r    <= 1'b0;
					len_r      <= '0;
				end
				prn_pkg::CMD_CPI10: begin
					cpi10_r <= 1'b1;
					dbl_r   <= 1'b0;
				end
				prn_pkg::CMD_CPI12: begin
					cpi10_r <= 1'b0;
					dbl_r   <= 1'b0;
				end
				prn_pkg::CMD_DOUBLE: dbl_r   <= 1'b1;
				prn_pkg::CMD_DMA:    param_r <= prn_pkg::P_DMA_LO;
				prn_pkg::CMD_LF_N:   param_r <= prn_pkg::P_LF;
				prn_pkg::CMD_TAB1:   param_r <= prn_pkg::P_TAB1;
				prn_pkg::CMD_TAB2:   param_r <= prn_pkg::P_TAB2;
				prn_pkg::CMD_TAB3:   param_r <= prn_pkg::P_TAB3;
				prn_pkg::CMD_RIGHT:  right_r <= 1'b1;
				prn_pkg::CMD_STROBE: param_r <= prn_pkg::P_STB;
				prn_pkg::CMD_CR:     len_r   <= '0;
				default: ;
			endcase
		end else if (take && is_chr) begin
			buf_r[len_r] <= 6'(in_byte_r - prn_pkg::CHR_FIRST);
			len_r        <= full_now ? 6'h00 : len_r + 6'h01;
		end
	end

	// ********************************
	// Print engine
	// ********************************
	// Double width shows each column twice; column 7 is the gap
	always_comb begin
		col_cyc  = cpi10_r ? COL10_CYC : COL12_CYC;
		col_last = dbl_r ? 4'hF : 4'h7;
		gcol     = dbl_r ? col_r[3:1] : col_r[2:0];
		gcol     = (right_r && gcol != 3'h7) ? 3'h6 - gcol : gcol;
		chr_idx  = right_r ? pr_len_r - 6'h01 - idx_r : idx_r;
		stb_cyc  = CW'((prn_pkg::STB_BASE_US + prn_pkg::STB_STEP_US * int'(stb_code_r)) * MHZ);
		fire     = (eng_r == prn_pkg::ENG_COL) && (cnt_r < stb_cyc);
	end

	// Decoder only runs while idle, so the buffer is stable while printing
	always_ff @(posedge mclk_i) begin
		if (rst_r) begin
			eng_r     <= prn_pkg::ENG_IDLE;
			cnt_r     <= '0;
			idx_r     <= '0;
			col_r     <= '0;
			pr_len_r  <= '0;
			lf_left_r <= '0;
		end else begin
			case (eng_r)
				prn_pkg::ENG_IDLE: begin
					cnt_r <= '0;
					idx_r <= '0;
					col_r <= '0;
					if (start_print && prn_len_nxt != 6'h00) begin
						pr_len_r <= prn_len_nxt;
						eng_r    <= prn_pkg::ENG_COL;
					end else if (feed_cmd) begin
						lf_left_r <= feed_n;
						eng_r     <= prn_pkg::ENG_FEED;
					end else if (form_cmd) begin
						eng_r <= prn_pkg::ENG_FORM;
					end
				end
				prn_pkg::ENG_COL: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == col_cyc - 1'b1) begin
						cnt_r <= '0;
						col_r <= col_r + 4'h1;
						if (col_r == col_last) begin
							col_r <= '0;
							idx_r <= idx_r + 6'h01;
							if (idx_r == pr_len_r - 6'h01) begin
								eng_r <= prn_pkg::ENG_PARK;
							end
						end
					end
				end
				prn_pkg::ENG_PARK: if (pin_r.park) eng_r <= prn_pkg::ENG_IDLE;
				prn_pkg::ENG_FEED: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == LF_CYC - 1'b1) begin
						cnt_r     <= '0;
						lf_left_r <= lf_left_r - 8'h01;
						if (lf_left_r == 8'h01) begin
							eng_r <= prn_pkg::ENG_IDLE;
						end
					end
				end
				prn_pkg::ENG_FORM: if (pin_r.form) eng_r <= prn_pkg::ENG_IDLE;
				default: eng_r <= prn_pkg::ENG_IDLE;
			endcase
		end
	end

	// ********************************
	// Output flops
	// ********************************
	// Needles follow the strobe window; motors and needles are active low
	always_ff @(posedge mclk_i) begin
		if (rst_r) begin
			needle_n_r <= '1;
			stb_out_r  <= 1'b0;
			main_n_r   <= 1'b1;
			feed_n_r   <= 1'b1;
		end else begin
			needle_n_r <= ~((fire && gcol != 3'h7) ? glyph(buf_r[chr_idx], gcol) : 7'h00);
			stb_out_r  <= fire;
			main_n_r   <= !(eng_r == prn_pkg::ENG_COL || eng_r == prn_pkg::ENG_PARK);
			feed_n_r   <= !(eng_r == prn_pkg::ENG_FEED || eng_r == prn_pkg::ENG_FORM ||
				(eng_r == prn_pkg::ENG_IDLE && pin_r.advance));
		end
	end

	// Shared pins change role with the strapped mode
	always_ff @(posedge mclk_i) begin
		if (rst_r) begin
			req_r <= 1'b0;
			irq_r <= 1'b0;
			oe_r  <= 1'b0;
		end else begin
			req_r <= serial_r ? (!ibf_r && !rx_busy_r) : (dma_r && !ibf_r);
			irq_r <= strap_done_r && !serial_r && !ibf_r && !dma_r;
			oe_r  <= strap_done_r && !serial_r;
		end
	end

	// Free-running cycle strobe, half period per count
	always_ff @(posedge mclk_i) begin
		if (rst_r) begin
			sync_cnt_r <= '0;
			cyc_r      <= 1'b0;
		end else if (sync_cnt_r == CW'(SYNC_HALF - 1)) begin
			sync_cnt_r <= '0;
			cyc_r      <= !cyc_r;
		end else begin
			sync_cnt_r <= sync_cnt_r + 1'b1;
		end
	end

	assign prdata_o                 = prdata_r;
	assign pready_o                 = pready_r;
	assign pslverr_o                = pslverr_r;
	assign request_or_send_ok_o     = req_r;
	assign irq_or_serial_strap_o    = irq_r;
	assign irq_or_serial_strap_oe_o = oe_r;
	assign main_drive_out_n_o       = main_n_r;
	assign feed_drive_out_n_o       = feed_n_r;
	assign solenoid_pulse_out_o     = stb_out_r;
	assign needle_drive_outs_n_o    = needle_n_r;
	assign aux_out_one_o            = aux1_r;
	assign aux_out_two_o            = aux2_r;
	assign cycle_strobe_o           = cyc_r;

	// ********************************
	// Assertions
	// ********************************
	always_ff @(posedge mclk_i) begin
		stb_len_r <= stb_out_r ? stb_len_r + 1'b1 : '0;
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_r);

	a_reset_defaults: assert property ($fell(rst_r) |->
		!cpi10_r && !dbl_r && stb_code_r == prn_pkg::STB_RESET_CODE && aux1_r)
		else $error("Reset defaults wrong");
	a_full_starts: assert property (start_print && full_now |=>
		eng_r == prn_pkg::ENG_COL && len_r == 6'h00)
		else $error("Full buffer did not start print");
	a_aux_follows: assert property (take && param_r == prn_pkg::P_NONE &&
		in_byte_r == prn_pkg::CMD_AUX1_CLR |=> !aux1_r ##1 !aux_out_one_o)
		else $error("Aux output not cleared");
	a_reset_param: assert property (take && param_r == prn_pkg::P_STB &&
		in_byte_r == prn_pkg::CMD_RESET |=> stb_code_r == 3'h4 && param_r == prn_pkg::P_NONE)
		else $error("Reset code not taken as parameter");
	a_density_cmd: assert property (take && param_r == prn_pkg::P_NONE &&
		in_byte_r == prn_pkg::CMD_CPI10 |=> cpi10_r && !dbl_r)
		else $error("Density command failed");
	a_dma_order: assert property (take && param_r == prn_pkg::P_DMA_LO |=>
		param_r == prn_pkg::P_DMA_HI && dma_cnt_r[7:0] == $past(in_byte_r))
		else $error("DMA count order wrong");
	a_tab_store: assert property (take && param_r == prn_pkg::P_TAB1 |=>
		tab_r[0] == $past(in_byte_r))
		else $error("Tab stop not stored");
	a_lf_count: assert property (feed_cmd && param_r == prn_pkg::P_LF |=>
		eng_r == prn_pkg::ENG_FEED && lf_left_r == $past(in_byte_r) ##1 !feed_drive_out_n_o)
		else $error("Line feed count not loaded");
	a_form_hold: assert property (eng_r == prn_pkg::ENG_FORM && !pin_r.form |=>
		eng_r == prn_pkg::ENG_FORM && !feed_drive_out_n_o)
		else $error("Form feed ended early");
	a_cr_prints: assert property (start_print && len_r != 6'h00 && !full_now |=>
		eng_r == prn_pkg::ENG_COL && pr_len_r == $past(len_r))
		else $error("Carriage return did not print");
	a_strobe_width: assert property ($fell(stb_out_r) |-> stb_len_r == stb_cyc)
		else $error("Strobe width wrong");
	a_select_gate: assert property (!ibf_r && !psel_i && !rx_done_r |=> !ibf_r)
		else $error("Byte taken without select");
	a_dma_end: assert property (wr_ok && dma_r && dma_cnt_r == 16'h0001 |=>
		!dma_r && !status[prn_pkg::ST_DMA])
		else $error("DMA flag not cleared");

	c_line_printed: cover property (eng_r == prn_pkg::ENG_PARK ##1 eng_r == prn_pkg::ENG_IDLE);
	c_dma_done: cover property ($fell(dma_r));
	c_form_feed: cover property (eng_r == prn_pkg::ENG_FORM ##1 eng_r == prn_pkg::ENG_IDLE);
	c_serial_byte: cover property (rx_done_r);
endmodule : prn_ctrl

/* shared/prn_pkg.sv */
// Constants and types shared by the printer controller
package prn_pkg;
	// ********************************
	// Register map and status bits
	// ********************************
	localparam logic [7:0] ADDR_DATA   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam int         ST_PARAM    = 5;
	localparam int         ST_DMA      = 4;
	localparam int         ST_FULL     = 1;
	// ********************************
	// Command and character codes
	// ********************************
	localparam logic [7:0] CMD_AUX1_SET = 8'h00;
	localparam logic [7:0] CMD_AUX2_SET = 8'h01;
	localparam logic [7:0] CMD_AUX1_CLR = 8'h02;
	localparam logic [7:0] CMD_AUX2_CLR = 8'h03;
	localparam logic [7:0] CMD_RESET    = 8'h04;
	localparam logic [7:0] CMD_CPI10    = 8'h05;
	localparam logic [7:0] CMD_CPI12    = 8'h06;
	localparam logic [7:0] CMD_DOUBLE   = 8'h07;
	localparam logic [7:0] CMD_DMA      = 8'h08;
	localparam logic [7:0] CMD_LF       = 8'h0A;
	localparam logic [7:0] CMD_LF_N     = 8'h0B;
	localparam logic [7:0] CMD_FORM     = 8'h0C;
	localparam logic [7:0] CMD_CR       = 8'h0D;
	localparam logic [7:0] CMD_TAB1     = 8'h0E;
	localparam logic [7:0] CMD_TAB2     = 8'h0F;
	localparam logic [7:0] CMD_TAB3     = 8'h10;
	localparam logic [7:0] CMD_RIGHT    = 8'h11;
	localparam logic [7:0] CMD_STROBE   = 8'h12;
	localparam logic [7:0] CHR_FIRST    = 8'h20;
	localparam logic [7:0] CHR_LAST     = 8'h5F;
	// ********************************
	// Line lengths, resets, timing
	// ********************************
	localparam logic [5:0] LINE_12        = 6'h28;
	localparam logic [5:0] LINE_10        = 6'h20;
	localparam int         LINE_MAX       = 40;
	localparam logic [2:0] STB_RESET_CODE = 3'h3;
	localparam int         SYNC_NS        = 2500;
	localparam int         STB_BASE_US    = 200;
	localparam int         STB_STEP_US    = 40;
	localparam int         COL12_US       = 600;
	localparam int         COL10_US       = 720;
	localparam int         LF_US          = 20000;
	localparam int         CNT_W          = 24;
	// Baud rate for each strap code; the two top codes share one rate
	function automatic int baud_rate(input logic [2:0] c);
		case (c)
			3'h0:    return 110;
			3'h1:    return 150;
			3'h2:    return 300;
			3'h3:    return 600;
			3'h4:    return 1200;
			3'h5:    return 2400;
			default: return 4800;
		endcase
	endfunction : baud_rate
	// ********************************
	// Types
	// ********************************
	typedef struct packed {
		logic [2:0] baud;
		logic       strap;
		logic       ack;
		logic       park;
		logic       form;
		logic       advance;
	} pins_t;
	typedef enum {ENG_IDLE, ENG_COL, ENG_PARK, ENG_FEED, ENG_FORM} eng_t;
	typedef enum {P_NONE, P_DMA_LO, P_DMA_HI, P_LF, P_TAB1, P_TAB2, P_TAB3, P_STB} param_t;
endpackage : prn_pkg

/* test/prn_ctrl_tb.sv */
// Bench for the printer controller: APB host, DMA far side, strobe timing
`timescale 1ns/100ps
module prn_ctrl_tb;
	// ****
	// Signals, design and far side
	// ****
	logic        mclk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, hold = 1;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd;
	logic        pready_o, pslverr_o, ack_or_serial_in_i, request_or_send_ok_o;
	logic        irq_or_serial_strap_o, irq_or_serial_strap_oe_o, head_park_i;
	logic        main_drive_out_n_o, solenoid_pulse_out_o, aux_out_one_o, aux_out_two_o;
	logic        feed_drive_out_n_o, form = 0;
	logic [6:0]  needle_drive_outs_n_o;
	int          err_count = 0, checks_done = 0, m_aux1 = 1, m_aux2 = 0;
	initial forever #25 mclk_i = !mclk_i;
	// Strap pin is pulled up, so the design wakes in parallel mode
	prn_ctrl #(.CLK_HZ(1_000_000)) DUT (.mclk_i, .reset_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ack_or_serial_in_i,
		.request_or_send_ok_o, .irq_or_serial_strap_o, .irq_or_serial_strap_oe_o,
		.irq_or_serial_strap_i(irq_or_serial_strap_oe_o ? irq_or_serial_strap_o : 1'b1),
		.baud_strap_i(3'h0), .paper_advance_switch_i(1'b0), .form_top_sense_i(form),
		.head_park_i, .main_drive_out_n_o, .feed_drive_out_n_o, .solenoid_pulse_out_o,
		.needle_drive_outs_n_o, .aux_out_one_o, .aux_out_two_o, .cycle_strobe_o());
	prn_far_model far (.mclk_i, .reset_i, .request_i(request_or_send_ok_o), .hold_i(hold),
		.ack_o(ack_or_serial_in_i), .main_drive_n_i(main_drive_out_n_o),
		.pulse_i(solenoid_pulse_out_o), .park_o(head_park_i));
	// ****
	// Tasks
	// ****
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	// One APB transfer; the request is held until pready is seen
	task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		psel_i <= 1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= {24'h00_0000, d};
		@(posedge mclk_i);
		penable_i <= 1;
		// Wait for the answer; only the watchdog ends a hung access
		do @(posedge mclk_i);
		while (pready_o !== 1'b1);
		rd = prdata_o;
		psel_i <= 0;
		penable_i <= 0;
	endtask : apb
	// Poll until the input is free, since a write while full is lost
	task put(input logic [7:0] d);
		do apb(0, prn_pkg::ADDR_STATUS, 8'h00);
		while (rd[prn_pkg::ST_FULL] !== 1'b0);
		apb(1, prn_pkg::ADDR_DATA, d);
	endtask : put
	// DMA write: pin inputs are filtered, so let the acknowledge settle first
	task dput(input logic [7:0] d);
		repeat (12) @(posedge mclk_i);
		while (ack_or_serial_in_i !== 1'b1) @(posedge mclk_i);
		repeat (8) @(posedge mclk_i);
		apb(1, prn_pkg::ADDR_DATA, d);
	endtask : dput
	// Print one character, then time strobe width and column period
	task print(input int code, input int col);
		int n;
		put(8'($urandom_range(33, 95)));
		put(prn_pkg::CMD_CR);
		while (solenoid_pulse_out_o !== 1'b1) @(posedge mclk_i);
		chk(main_drive_out_n_o, 0, "main motor");
		n = 0;
		for (int p = 0; p < 2; p++) begin
			do begin
				@(posedge mclk_i);
				n++;
			end while (solenoid_pulse_out_o !== 1'(p));
			chk(n, p ? col : prn_pkg::STB_BASE_US + prn_pkg::STB_STEP_US * code, "strobe");
			if (p == 0) chk(needle_drive_outs_n_o, 7'h7F, "needles off");
		end
	endtask : print
	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	// ****
	// Tests
	// ****
	initial begin
		logic [7:0] b;
		void'($urandom(24));
		repeat (6) @(posedge mclk_i);
		reset_i <= 0;
		repeat (8) @(posedge mclk_i);
		apb(0, prn_pkg::ADDR_STATUS, 8'h00);
		chk(rd, 32'h0000_0000, "status");
		chk(irq_or_serial_strap_o, 1, "irq idle");
		apb(0, {6'($urandom_range(2, 63)), 2'b00}, 8'h00);
		chk(pslverr_o, 1, "unmapped");
		for (int c = 0; c < 4; c++) begin
			put(8'(c));
			if (c % 2) m_aux2 = c < 2;
			else m_aux1 = c < 2;
			repeat (8) @(posedge mclk_i);
			chk(aux_out_one_o, m_aux1, "aux one");
			chk(aux_out_two_o, m_aux2, "aux two");
		end
		$display("test aux done");
		print(prn_pkg::STB_RESET_CODE, prn_pkg::COL12_US);
		put(prn_pkg::CMD_STROBE);
		// The engine is still busy, so wait until the command is taken
		do apb(0, prn_pkg::ADDR_STATUS, 8'h00);
		while (rd[prn_pkg::ST_FULL] !== 1'b0);
		chk(rd, 32'h0000_0020, "param pending");
		put(prn_pkg::CMD_RESET);
		put(prn_pkg::CMD_DOUBLE);
		put(prn_pkg::CMD_RIGHT);
		print(4, prn_pkg::COL12_US);
		b = 8'($urandom);
		put(prn_pkg::CMD_STROBE);
		put(b);
		put(prn_pkg::CMD_CPI10);
		print(b[2:0], prn_pkg::COL10_US);
		put(prn_pkg::CMD_RESET);
		print(prn_pkg::STB_RESET_CODE, prn_pkg::COL12_US);
		$display("test print done");
		put(prn_pkg::CMD_DMA);
		put(8'h02);
		put(8'h00);
		repeat (8) @(posedge mclk_i);
		apb(0, prn_pkg::ADDR_STATUS, 8'h00);
		chk(rd, 32'h0000_0010, "dma active");
		apb(1, prn_pkg::ADDR_DATA, prn_pkg::CMD_AUX1_SET);
		repeat (8) @(posedge mclk_i);
		chk(aux_out_one_o, 0, "write without ack");
		hold <= 0;
		dput(prn_pkg::CMD_AUX2_SET);
		dput(prn_pkg::CMD_AUX1_SET);
		repeat (12) @(posedge mclk_i);
		chk({aux_out_one_o, aux_out_two_o}, 3, "dma writes");
		apb(0, prn_pkg::ADDR_STATUS, 8'h00);
		chk(rd, 32'h0000_0000, "dma over");
		chk(irq_or_serial_strap_o, 1, "irq after dma");
		$display("test dma done");
		put(prn_pkg::CMD_LF_N);
		put(8'h01);
		repeat (8) @(posedge mclk_i);
		chk(feed_drive_out_n_o, 0, "line feed");
		put(prn_pkg::CMD_TAB1);
		put(8'h05);
		put(prn_pkg::CMD_FORM);
		// Feed motor runs until the sense input rises
		do apb(0, prn_pkg::ADDR_STATUS, 8'h00);
		while (rd[prn_pkg::ST_FULL] !== 1'b0);
		repeat (4) @(posedge mclk_i);
		chk(feed_drive_out_n_o, 0, "form feed");
		form <= 1;
		repeat (12) @(posedge mclk_i);
		chk(feed_drive_out_n_o, 1, "top of form");
		$display("test feed done");
		end_sim();
	end
	// Watchdog well beyond the expected run length
	initial begin
		repeat (90000) @(posedge mclk_i);
		err_count++;
		end_sim();
	end
endmodule : prn_ctrl_tb

/* test/prn_far_model.sv */
// Far-side model: DMA channel answering requests, and the print carriage
`timescale 1ns/100ps
module prn_far_model (
	// Clock and reset
	input  wire logic mclk_i,
	input  wire logic reset_i,
	// DMA channel and carriage
	input  wire logic request_i,
	input  wire logic hold_i,
	input  wire logic main_drive_n_i,
	input  wire logic pulse_i,
	output logic      ack_o,
	output logic      park_o
);
	// ****
	// Behaviour
	// ****
	int quiet_r = 0;
	// Acknowledge trails a request by a cycle; the bench may stall the channel
	always_ff @(posedge mclk_i) begin
		ack_o <= !reset_i && request_i && !hold_i;
	end
	// Head leaves rest while the motor runs, is back once strobes stop a while
	always_ff @(posedge mclk_i) begin
		quiet_r <= (main_drive_n_i || pulse_i) ? 0 : quiet_r + 1;
	end
	assign park_o = main_drive_n_i || quiet_r > 1000;
endmodule : prn_far_model
